// *** verilog/blro_pkg.sv ***
package blro_pkg;
	// register byte offsets on the bus
	localparam logic [11:0] BLRO_OFF_FG = 12'h034;
	localparam logic [11:0] BLRO_OFF_BG = 12'h038;
	localparam logic [11:0] BLRO_OFF_PIXDEPTH = 12'h07c;
	localparam logic [11:0] BLRO_OFF_ROP = 12'h08c;
	localparam logic [11:0] BLRO_OFF_SRCBASE = 12'h098;
	localparam logic [11:0] BLRO_OFF_STCOMP = 12'h0ec;
	localparam logic [11:0] BLRO_OFF_DTCOMP = 12'h0fc;
	localparam logic [11:0] BLRO_OFF_HOSTDATA = 12'h100;
	localparam int BLRO_ADDR_W = 12;

	// raster_operation_control field positions
	localparam int BLRO_SRC_HI = 31;
	localparam int BLRO_SRC_LO = 30;
	localparam int BLRO_PAT_USE = 29;
	localparam int BLRO_DST_USE = 28;
	localparam int BLRO_DIAG = 27;
	localparam int BLRO_DT_EN = 15;
	localparam int BLRO_DT_MATCH = 14;
	localparam int BLRO_ST_EN = 13;
	localparam int BLRO_ST_MATCH = 12;
	localparam int BLRO_PACKED = 11;
	localparam int BLRO_EXPAND = 10;
	localparam int BLRO_PAT_TR = 9;
	localparam int BLRO_BM_TR = 8;
	localparam int BLRO_CODE_HI = 7;

	// writable bits and reset values
	localparam logic [31:0] BLRO_ROP_WMASK = 32'hf800ffff;
	localparam logic [31:0] BLRO_SRCBASE_WMASK = 32'h003fffe0;
	localparam logic [31:0] BLRO_DEPTH_WMASK = 32'h00000003;
	localparam logic [31:0] BLRO_FG_RST = 32'hffffffff;
	localparam logic [31:0] BLRO_BG_RST = 32'h00000000;
	localparam logic [31:0] BLRO_ZERO = 32'h00000000;
	localparam int BLRO_BASE_HI = 21;
	localparam int BLRO_BASE_LO = 5;

	// byte-lane masks per pixel depth
	localparam logic [31:0] BLRO_MASK_1B = 32'h000000ff;
	localparam logic [31:0] BLRO_MASK_2B = 32'h0000ffff;
	localparam logic [31:0] BLRO_MASK_3B = 32'h00ffffff;
	localparam logic [31:0] BLRO_MASK_4B = 32'hffffffff;

	// source operand type and pixel depth encodings
	typedef enum logic [1:0] {BLRO_SRC_FILL, BLRO_SRC_SCREEN, BLRO_SRC_HOST, BLRO_SRC_RSVD} blro_src_t;
	typedef enum logic [1:0] {BLRO_DEP_1B, BLRO_DEP_2B, BLRO_DEP_3B, BLRO_DEP_4B} blro_depth_t;
endpackage

// *** verilog/blro_rop_ctrl.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R01 - source type picks fill, screen or host
// R02 - host port writes always accepted, kept only if host
// R03 - software uses fill source when code ignores source
// R04 - pattern-present enables pattern fetch and operand
// R05 - destination-present enables destination read
// R06 - diagnostic bit reroutes register reads
// R07 - destination transparency compares destination with compare
// R08 - destination match bit selects equal or differing
// R09 - software sets destination-present, avoids three-byte pixels
// R10 - source transparency compares colour source, not 3-byte
// R11 - source match bit selects equal or differing
// R12 - software uses bitmap transparency for bitmap sources
// R13 - packed mode carries leftover source to next line
// R14 - unpacked mode drops leftover source at line end
// R15 - expand bit treats source as one-bit bitmap
// R16 - pattern transparency skips zero pattern pixels
// R17 - bitmap transparency skips zero bits, writes foreground
// R18 - result computed from eight-bit raster code
// R19 - source start address from base bits 21:5
// R20 - source base low five bits stay zero
// R21 - fourth byte of four-byte pixels is processed
// R22 - depth field gives one to four bytes
// R23 - expansion substitutes foreground for one bits
// R24 - raster code is truth table on pattern, source, destination
module blro_rop_ctrl (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// pixel operands from the engine's fetch units
	input wire logic pix_valid,
	input wire logic [31:0] pix_pat,
	input wire logic [31:0] pix_src,
	input wire logic [31:0] pix_dst,
	input wire logic pix_bit,
	input wire logic line_end,
	// pixel result
	output logic res_valid,
	output logic [31:0] res_data,
	output logic res_write,
	// fetch steering
	output logic [1:0] src_sel,
	output logic fetch_pat,
	output logic fetch_dst,
	output logic bitmap_src,
	output logic packed_src,
	output logic src_discard,
	output logic [21:0] src_start_addr,
	output logic [1:0] pixel_depth,
	// host data port forwarded to the engine
	output logic host_valid,
	output logic [31:0] host_data
);
	import blro_pkg::*;

	logic [31:0] rop_q;
	logic [31:0] srcbase_q;
	logic [31:0] depth_q;
	logic [31:0] fg_q;
	logic [31:0] bg_q;
	logic [31:0] stc_q;
	logic [31:0] dtc_q;
	logic [31:0] host_q;
	logic host_valid_q;
	logic wr_pend_q;
	logic [BLRO_ADDR_W-1:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic res_valid_q;
	logic [31:0] res_q;
	logic res_write_q;
	logic discard_q;
	logic addr_ok;
	logic [BLRO_ADDR_W-1:0] a_off;
	logic [31:0] rd_d;
	logic [31:0] src_col;
	logic [31:0] pat_op;
	logic [31:0] dst_op;
	logic [31:0] res_d;
	logic write_d;
	logic [31:0] dmask;
	blro_src_t src_type;
	blro_depth_t depth;

	// byte lanes that belong to one pixel at the given depth
	function automatic logic [31:0] blro_mask(input blro_depth_t d);
		case (d)
			BLRO_DEP_1B: blro_mask = BLRO_MASK_1B;
			BLRO_DEP_2B: blro_mask = BLRO_MASK_2B;
			BLRO_DEP_3B: blro_mask = BLRO_MASK_3B;
			default: blro_mask = BLRO_MASK_4B;
		endcase
	endfunction

	// masked pixel compare, used by destination and source transparency
	function automatic logic blro_eq(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
		blro_eq = ((a & m) == (b & m));
	endfunction

	// each result bit is the code bit indexed by {pat, src, dst}
	function automatic logic [31:0] blro_rop(input logic [7:0] code, input logic [31:0] p,
		input logic [31:0] s, input logic [31:0] d);
		logic [31:0] r;
		r = BLRO_ZERO;
		for (int i = 0; i < 32; i++) begin
			r[i] = code[{p[i], s[i], d[i]}];
		end
		blro_rop = r;
	endfunction

	assign src_type = blro_src_t'(rop_q[BLRO_SRC_HI:BLRO_SRC_LO]);
	assign depth = blro_depth_t'(depth_q[1:0]);
	assign dmask = blro_mask(depth); // R22
	assign a_off = haddr[BLRO_ADDR_W-1:0];
	assign addr_ok = hsel && hready && htrans[1];

	// register read mux; diagnostic mode returns the result path for all but the control and host data offsets
	always_comb begin
		rd_d = BLRO_ZERO;
		case (a_off)
			BLRO_OFF_FG: rd_d = fg_q;
			BLRO_OFF_BG: rd_d = bg_q;
			BLRO_OFF_PIXDEPTH: rd_d = depth_q;
			BLRO_OFF_ROP: rd_d = rop_q;
			BLRO_OFF_SRCBASE: rd_d = srcbase_q;
			BLRO_OFF_STCOMP: rd_d = stc_q;
			BLRO_OFF_DTCOMP: rd_d = dtc_q;
			BLRO_OFF_HOSTDATA: rd_d = host_q;
			default: rd_d = BLRO_ZERO;
		endcase
		// control register stays readable so software can leave the mode
		if (rop_q[BLRO_DIAG] && a_off != BLRO_OFF_ROP && a_off != BLRO_OFF_HOSTDATA) begin
			rd_d = res_q; // R06
		end
	end

	// address phase capture; zero wait states, reads answered next cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q <= BLRO_ZERO;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_addr_q <= a_off;
			end
			if (addr_ok && !hwrite) begin
				hrdata_q <= rd_d;
			end
		end
	end

	// data phase register writes; reserved bits never take a one
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rop_q <= BLRO_ZERO;
			srcbase_q <= BLRO_ZERO;
			depth_q <= BLRO_ZERO;
			fg_q <= BLRO_FG_RST;
			bg_q <= BLRO_BG_RST;
			stc_q <= BLRO_ZERO;
			dtc_q <= BLRO_ZERO;
		end else if (wr_pend_q) begin
			case (wr_addr_q)
				BLRO_OFF_FG: fg_q <= hwdata;
				BLRO_OFF_BG: bg_q <= hwdata;
				BLRO_OFF_PIXDEPTH: depth_q <= hwdata & BLRO_DEPTH_WMASK;
				BLRO_OFF_ROP: rop_q <= hwdata & BLRO_ROP_WMASK;
				BLRO_OFF_SRCBASE: srcbase_q <= hwdata & BLRO_SRCBASE_WMASK; // R20
				BLRO_OFF_STCOMP: stc_q <= hwdata;
				BLRO_OFF_DTCOMP: dtc_q <= hwdata;
				default: ;
			endcase
		end
	end

	// host data port: every write completes, data kept only for host source
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_q <= BLRO_ZERO;
			host_valid_q <= 1'b0;
		end else begin
			host_valid_q <= 1'b0;
			if (wr_pend_q && wr_addr_q == BLRO_OFF_HOSTDATA && src_type == BLRO_SRC_HOST) begin // R02
				host_q <= hwdata;
				host_valid_q <= 1'b1;
			end
		end
	end

	// operand selection and write decision for one pixel
	always_comb begin
		pat_op = rop_q[BLRO_PAT_USE] ? pix_pat : BLRO_ZERO; // R04
		dst_op = rop_q[BLRO_DST_USE] ? pix_dst : BLRO_ZERO; // R05
		case (src_type) // R01
			BLRO_SRC_SCREEN: src_col = pix_src;
			BLRO_SRC_HOST: src_col = host_q;
			default: src_col = bg_q;
		endcase
		// bitmap data only expands when it comes from screen or host
		if (rop_q[BLRO_EXPAND] && (src_type == BLRO_SRC_SCREEN || src_type == BLRO_SRC_HOST)) begin // R15
			src_col = pix_bit ? fg_q : bg_q; // R23
		end
		// all 32 bits go through the code, fourth byte included
		res_d = blro_rop(rop_q[BLRO_CODE_HI:0], pat_op, src_col, dst_op); // R18 R24 R21
		write_d = 1'b1;
		// compare modes are meaningless at three bytes, so they stand down
		if (rop_q[BLRO_DT_EN] && depth != BLRO_DEP_3B) begin // R07
			write_d = write_d && (blro_eq(dst_op, dtc_q, dmask) == rop_q[BLRO_DT_MATCH]); // R08
		end
		if (rop_q[BLRO_ST_EN] && !rop_q[BLRO_EXPAND] && depth != BLRO_DEP_3B) begin // R10
			write_d = write_d && (blro_eq(src_col, stc_q, dmask) == rop_q[BLRO_ST_MATCH]); // R11
		end
		if (rop_q[BLRO_PAT_TR]) begin
			write_d = write_d && ((pat_op & dmask) != BLRO_ZERO); // R16
		end
		if (rop_q[BLRO_BM_TR] && rop_q[BLRO_EXPAND]) begin
			write_d = write_d && pix_bit; // R17
		end
	end

	// one-stage result pipe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			res_valid_q <= 1'b0;
			res_q <= BLRO_ZERO;
			res_write_q <= 1'b0;
		end else begin
			res_valid_q <= pix_valid;
			if (pix_valid) begin
				res_q <= res_d;
				res_write_q <= write_d;
			end
		end
	end

	// line end: unpacked mode tells the fetcher to drop its leftover dword
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			discard_q <= 1'b0;
		end else begin
			discard_q <= line_end && !rop_q[BLRO_PACKED]; // R13 R14
		end
	end

	// outputs, all straight from flops except the tied-off hreadyout and hresp
	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1; // never stalls, so no reset-time glitch either
	assign hresp = 1'b0;
	assign res_valid = res_valid_q;
	assign res_data = res_q;
	assign res_write = res_write_q;
	assign src_sel = rop_q[BLRO_SRC_HI:BLRO_SRC_LO];
	assign fetch_pat = rop_q[BLRO_PAT_USE];
	assign fetch_dst = rop_q[BLRO_DST_USE];
	assign bitmap_src = rop_q[BLRO_EXPAND];
	assign packed_src = rop_q[BLRO_PACKED];
	assign src_discard = discard_q;
	assign src_start_addr = srcbase_q[BLRO_BASE_HI:0]; // R19
	assign pixel_depth = depth_q[1:0];
	assign host_valid = host_valid_q;
	assign host_data = host_q;

	// host write with host source shows up one cycle later
	property p_host_take;
		@(posedge core_clk) disable iff (!rst_n)
		wr_pend_q && wr_addr_q == BLRO_OFF_HOSTDATA && src_type == BLRO_SRC_HOST
		|=> host_valid && host_data == $past(hwdata);
	endproperty
	a_host_take: assert property (p_host_take) else $error("host data not forwarded"); // R02

	// host write with another source leaves the port untouched
	property p_host_drop;
		@(posedge core_clk) disable iff (!rst_n)
		wr_pend_q && wr_addr_q == BLRO_OFF_HOSTDATA && src_type != BLRO_SRC_HOST
		|=> !host_valid && $stable(host_data);
	endproperty
	a_host_drop: assert property (p_host_drop) else $error("host data kept without host source"); // R02

	// low base bits and reserved top bits never set
	property p_base_align;
		@(posedge core_clk) disable iff (!rst_n)
		src_start_addr[BLRO_BASE_LO-1:0] == '0 && srcbase_q[31:BLRO_BASE_HI+1] == '0;
	endproperty
	a_base_align: assert property (p_base_align) else $error("source base not aligned"); // R20

	// code f0 with pattern in use yields the pattern itself
	property p_code_pat;
		@(posedge core_clk) disable iff (!rst_n)
		pix_valid && rop_q[BLRO_CODE_HI:0] == 8'hf0 && rop_q[BLRO_PAT_USE] |=> res_data == $past(pix_pat);
	endproperty
	a_code_pat: assert property (p_code_pat) else $error("pattern copy code wrong"); // R24

	// destination equal to compare with match clear is not written
	property p_dst_tr;
		@(posedge core_clk) disable iff (!rst_n)
		pix_valid && rop_q[BLRO_DT_EN] && !rop_q[BLRO_DT_MATCH] && rop_q[BLRO_DST_USE]
		&& depth != BLRO_DEP_3B && ((pix_dst ^ dtc_q) & dmask) == BLRO_ZERO |=> !res_write;
	endproperty
	a_dst_tr: assert property (p_dst_tr) else $error("destination transparency wrote pixel"); // R08

	// screen source differing from compare with match set is not written
	property p_src_tr;
		@(posedge core_clk) disable iff (!rst_n)
		pix_valid && rop_q[BLRO_ST_EN] && rop_q[BLRO_ST_MATCH] && !rop_q[BLRO_EXPAND]
		&& src_type == BLRO_SRC_SCREEN && depth != BLRO_DEP_3B
		&& ((pix_src ^ stc_q) & dmask) != BLRO_ZERO |=> !res_write;
	endproperty
	a_src_tr: assert property (p_src_tr) else $error("source transparency wrote pixel"); // R11

	// zero pattern pixel under pattern transparency is never written
	property p_pat_tr;
		@(posedge core_clk) disable iff (!rst_n)
		pix_valid && rop_q[BLRO_PAT_TR] && (pix_pat & dmask) == BLRO_ZERO |=> !res_write;
	endproperty
	a_pat_tr: assert property (p_pat_tr) else $error("pattern transparency wrote pixel"); // R16

	// expanded one bit with source-copy code gives foreground
	property p_bm_fg;
		@(posedge core_clk) disable iff (!rst_n)
		pix_valid && pix_bit && rop_q[BLRO_EXPAND] && src_type == BLRO_SRC_SCREEN && rop_q[BLRO_CODE_HI:0] == 8'hcc
		|=> res_data == $past(fg_q) && (res_write || !$past(rop_q[BLRO_BM_TR])
		|| $past(rop_q[BLRO_PAT_TR]) || $past(rop_q[BLRO_DT_EN]));
	endproperty
	a_bm_fg: assert property (p_bm_fg) else $error("bitmap expansion did not give foreground"); // R23

	// zero bitmap bit under bitmap transparency is skipped
	property p_bm_skip;
		@(posedge core_clk) disable iff (!rst_n)
		pix_valid && rop_q[BLRO_EXPAND] && rop_q[BLRO_BM_TR] && !pix_bit |=> !res_write;
	endproperty
	a_bm_skip: assert property (p_bm_skip) else $error("bitmap transparency wrote pixel"); // R17

	// line end drops leftover source only when unpacked
	property p_line_end;
		@(posedge core_clk) disable iff (!rst_n)
		line_end |=> src_discard == !$past(rop_q[BLRO_PACKED]);
	endproperty
	a_line_end: assert property (p_line_end) else $error("line end discard wrong"); // R14

	// fill source feeds the background colour into the code, expand or not
	property p_fill_src;
		@(posedge core_clk) disable iff (!rst_n)
		pix_valid && src_type == BLRO_SRC_FILL && rop_q[BLRO_CODE_HI:0] == 8'hcc |=> res_data == $past(bg_q);
	endproperty
	a_fill_src: assert property (p_fill_src) else $error("fill source not background"); // R01

	// host source feeds the last accepted host word
	property p_host_src;
		@(posedge core_clk) disable iff (!rst_n)
		pix_valid && src_type == BLRO_SRC_HOST && !rop_q[BLRO_EXPAND] && rop_q[BLRO_CODE_HI:0] == 8'hcc
		|=> res_data == $past(host_data);
	endproperty
	a_host_src: assert property (p_host_src) else $error("host source not host word"); // R01

	// destination not in use reads as zero, so a destination copy gives zero
	property p_dst_off;
		@(posedge core_clk) disable iff (!rst_n)
		pix_valid && !rop_q[BLRO_DST_USE] && rop_q[BLRO_CODE_HI:0] == 8'haa |=> res_data == BLRO_ZERO;
	endproperty
	a_dst_off: assert property (p_dst_off) else $error("unused destination leaked"); // R05

	// a source base write keeps only the base field
	property p_base_write;
		@(posedge core_clk) disable iff (!rst_n)
		wr_pend_q && wr_addr_q == BLRO_OFF_SRCBASE |=> srcbase_q == ($past(hwdata) & BLRO_SRCBASE_WMASK);
	endproperty
	a_base_write: assert property (p_base_write) else $error("source base write not masked"); // R20
endmodule

// *** test/blro_host_bfm.sv ***
`timescale 1ns/1ps
// host cpu model: one single-word ahb-lite transfer at a time, never stalls on its own
module blro_host_bfm (
	// clock
	input wire logic core_clk,
	// ahb-lite master signals
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	// idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// address phase stands until hready is seen high at a rising edge
	task automatic addr_phase(input logic [11:0] off, input logic wr);
		// every request starts right on a rising edge
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {20'h0, off};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
	endtask

	// whole-word write; data stands through the data phase
	task automatic wr(input logic [11:0] off, input logic [31:0] d);
		addr_phase(off, 1'b1);
		hwdata <= d;
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		hwdata <= ~d; // released data lines must not keep showing the last word
	endtask

	// whole-word read; data taken at the edge that ends the data phase
	task automatic rd(input logic [11:0] off, output logic [31:0] d);
		addr_phase(off, 1'b0);
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		d = hrdata;
	endtask
endmodule

// *** test/blro_rop_ctrl_test.sv ***
`timescale 1ns/1ps
// registers go through the host model, pixels and line ends are driven here
module blro_rop_ctrl_test;
	import blro_pkg::*;
	// clock, reset and bus
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	// pixel stream inputs
	logic pix_valid = 1'b0;
	logic pix_bit = 1'b0;
	logic line_end = 1'b0;
	logic [31:0] pix_pat = 32'h0;
	logic [31:0] pix_src = 32'h0;
	logic [31:0] pix_dst = 32'h0;
	// design outputs
	logic res_valid, res_write, fetch_pat, fetch_dst, bitmap_src, packed_src, src_discard, host_valid;
	logic [31:0] res_data, host_data;
	logic [1:0] src_sel, pixel_depth;
	logic [21:0] src_start_addr;
	int fails = 0;
	int comparisons = 0;
	// each byte of these words holds all eight pattern/source/destination combinations
	localparam logic [31:0] P = 32'hf0f0f0f0;
	localparam logic [31:0] S = 32'hcccccccc;
	localparam logic [31:0] D = 32'haaaaaaaa;
	localparam logic [31:0] CMP = 32'h0badf00d;
	localparam logic [31:0] FG = 32'hcafe0011;
	localparam logic [31:0] BG = 32'h12345678;
	logic [7:0] codes [8] = '{8'h00, 8'hff, 8'hf0, 8'hcc, 8'haa, 8'h5a, 8'h66, 8'h96};

	// 250 MHz clock; single slave so hready is its hreadyout
	always #2 core_clk = ~core_clk;
	assign hready = hreadyout;

	blro_host_bfm host (.core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

	blro_rop_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pix_valid(pix_valid), .pix_pat(pix_pat), .pix_src(pix_src),
		.pix_dst(pix_dst), .pix_bit(pix_bit), .line_end(line_end), .res_valid(res_valid),
		.res_data(res_data), .res_write(res_write), .src_sel(src_sel), .fetch_pat(fetch_pat),
		.fetch_dst(fetch_dst), .bitmap_src(bitmap_src), .packed_src(packed_src), .src_discard(src_discard),
		.src_start_addr(src_start_addr), .pixel_depth(pixel_depth), .host_valid(host_valid),
		.host_data(host_data));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		chk({31'h0, got}, {31'h0, exp}, what);
	endtask

	task automatic note(input string what);
		$display("test %s done", what);
	endtask

	// write, then step off the edge so the new outputs have settled
	task automatic w(input logic [11:0] off, input logic [31:0] d);
		host.wr(off, d);
		#1;
	endtask

	task automatic rdc(input logic [11:0] off, input logic [31:0] exp, input string what);
		logic [31:0] v;
		host.rd(off, v);
		chk(v, exp, what);
	endtask

	// one pixel in, result looked at in the single cycle that res_valid stands
	task automatic pix(input logic [31:0] p, s, d, input logic b, input logic [31:0] exp, input logic we);
		@(posedge core_clk);
		pix_valid <= 1'b1;
		pix_pat <= p;
		pix_src <= s;
		pix_dst <= d;
		pix_bit <= b;
		@(posedge core_clk);
		pix_valid <= 1'b0;
		{pix_pat, pix_src, pix_dst} <= ~{p, s, d};
		#1;
		chk1(res_valid, 1'b1, "res_valid");
		chk1(res_write, we, "res_write");
		if (we) chk(res_data, exp, "res_data");
		@(posedge core_clk);
	endtask

	task automatic eol(input logic exp);
		@(posedge core_clk);
		line_end <= 1'b1;
		@(posedge core_clk);
		line_end <= 1'b0;
		#1;
		chk1(src_discard, exp, "src_discard");
		@(posedge core_clk);
	endtask

	task automatic close_out();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rdc(BLRO_OFF_ROP, BLRO_ZERO, "rop reset");
		rdc(BLRO_OFF_FG, BLRO_FG_RST, "fg reset");
		rdc(12'h0d4, BLRO_ZERO, "unmapped read");
		chk1(hresp, 1'b0, "hresp");
		note("reset");
		w(BLRO_OFF_ROP, 32'hffffffff);
		rdc(BLRO_OFF_ROP, BLRO_ROP_WMASK, "rop mask");
		chk({28'h0, fetch_pat, fetch_dst, bitmap_src, packed_src}, 32'hf, "steering");
		for (int k = 0; k < 4; k++) begin
			w(BLRO_OFF_ROP, {k[1:0], 30'h0});
			chk({26'h0, src_sel, fetch_pat, fetch_dst, bitmap_src, packed_src}, {26'h0, k[1:0], 4'h0}, "src");
		end
		note("control");
		w(BLRO_OFF_ROP, 32'h80000000);
		w(BLRO_OFF_HOSTDATA, 32'ha5a55a5a);
		chk1(host_valid, 1'b1, "host pulse");
		chk(host_data, 32'ha5a55a5a, "host word");
		@(posedge core_clk);
		#1;
		chk1(host_valid, 1'b0, "host pulse end");
		w(BLRO_OFF_ROP, 32'h40000000);
		w(BLRO_OFF_HOSTDATA, 32'h5a5aa5a5);
		chk1(host_valid, 1'b0, "host discard");
		chk(host_data, 32'ha5a55a5a, "host kept");
		note("host port");
		w(BLRO_OFF_SRCBASE, 32'hffffffff);
		rdc(BLRO_OFF_SRCBASE, BLRO_SRCBASE_WMASK, "base mask");
		chk({10'h0, src_start_addr}, 32'h003fffe0, "start addr");
		w(BLRO_OFF_SRCBASE, 32'h0001234f);
		chk({10'h0, src_start_addr}, 32'h00012340, "start low");
		for (int k = 0; k < 4; k++) begin
			w(BLRO_OFF_PIXDEPTH, 32'(k));
			chk({30'h0, pixel_depth}, 32'(k), "depth");
		end
		w(BLRO_OFF_ROP, 32'h0);
		eol(1'b1);
		w(BLRO_OFF_ROP, 32'h00000800);
		eol(1'b0);
		note("base depth line");
		// pixels at four bytes per pixel; top byte takes part like the rest
		w(BLRO_OFF_FG, FG);
		w(BLRO_OFF_BG, BG);
		w(BLRO_OFF_DTCOMP, CMP);
		w(BLRO_OFF_STCOMP, CMP);
		foreach (codes[i]) begin
			w(BLRO_OFF_ROP, 32'h70000000 | {24'h0, codes[i]});
			pix(P, S, D, 1'b0, {4{codes[i]}}, 1'b1);
		end
		w(BLRO_OFF_ROP, 32'h200000f0);
		pix(P, S, D, 1'b0, P, 1'b1);
		w(BLRO_OFF_ROP, 32'h000000cc);
		pix(P, S, D, 1'b0, BG, 1'b1);
		w(BLRO_OFF_ROP, 32'h800000cc);
		pix(P, S, D, 1'b0, 32'ha5a55a5a, 1'b1);
		w(BLRO_OFF_ROP, 32'h000000f0);
		pix(P, S, D, 1'b0, 32'h0, 1'b1);
		w(BLRO_OFF_ROP, 32'h100000aa);
		pix(P, S, D, 1'b0, D, 1'b1);
		w(BLRO_OFF_ROP, 32'h000000aa);
		pix(P, S, D, 1'b0, 32'h0, 1'b1);
		w(BLRO_OFF_ROP, 32'h400004cc);
		pix(P, S, D, 1'b1, FG, 1'b1);
		pix(P, S, D, 1'b0, BG, 1'b1);
		w(BLRO_OFF_ROP, 32'h400005cc);
		pix(P, S, D, 1'b0, FG, 1'b0);
		pix(P, S, D, 1'b1, FG, 1'b1);
		w(BLRO_OFF_ROP, 32'h600002cc);
		pix(32'h0, S, D, 1'b0, S, 1'b0);
		pix(32'h00000100, S, D, 1'b0, S, 1'b1);
		for (int m = 0; m < 2; m++) begin
			w(BLRO_OFF_ROP, 32'h500080cc | (32'(m) << 14));
			pix(P, S, ~CMP, 1'b0, S, m == 0);
			pix(P, S, CMP, 1'b0, S, m == 1);
			w(BLRO_OFF_ROP, 32'h400020cc | (32'(m) << 12));
			pix(P, ~CMP, D, 1'b0, ~CMP, m == 0);
			pix(P, CMP, D, 1'b0, CMP, m == 1);
		end
		note("pixels");
		w(BLRO_OFF_ROP, 32'h08000000);
		rdc(BLRO_OFF_BG, CMP, "diag read");
		rdc(BLRO_OFF_ROP, 32'h08000000, "diag rop");
		w(BLRO_OFF_ROP, 32'h0);
		rdc(BLRO_OFF_BG, BG, "normal read");
		note("diagnostic");
		close_out();
	end

	// the run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		fails++;
		$display("BAD %0t watchdog expired", $time);
		close_out();
	end
endmodule
